// File: sdcl_pkg.sv
// sdcl_pkg: shared constants and carrier types for the sdram device-side timing core
// assumes: one 25 MHz clock, commands sampled on the rising edge
package sdcl_pkg;
  localparam int DATA_W   = 32;
  localparam int LANES    = 4;
  localparam int BANK_W   = 2;
  localparam int ROW_W    = 11;
  localparam int COL_W    = 8;
  localparam int MEM_AW   = BANK_W + ROW_W + COL_W;
  // cycle counts
  localparam int SUSPEND_ENTRY_DELAY     = 1;
  localparam int SUSPEND_EXIT_DELAY      = 1;
  localparam int WRITE_MASK_LATENCY      = 0;
  localparam int READ_MASK_HIZ_LATENCY   = 2;
  localparam int WRITE_DATA_DELAY        = 0;
  localparam int PRECHARGE_TO_OUTPUT_HIZ_CL3 = 3;
  localparam int PRECHARGE_TO_OUTPUT_HIZ_CL2 = 2;
  // reset values
  localparam logic [1:0] READ_LATENCY_RESET = 2'h3;
  localparam logic [2:0] BURST_LEN_RESET    = 3'h0;

  // command codes as {rasN, casN, weN}
  typedef enum logic [2:0] {
    CMD_MODE  = 3'b000,
    CMD_REFR  = 3'b001,
    CMD_PRE   = 3'b010,
    CMD_ACT   = 3'b011,
    CMD_WRITE = 3'b100,
    CMD_READ  = 3'b101,
    CMD_STOP  = 3'b110,
    CMD_NOP   = 3'b111
  } sdcl_cmd_t;

  // command bus from the controller
  typedef struct packed {
    logic              chipSelN;
    logic              rowStrobeN;
    logic              colStrobeN;
    logic              writeEnN;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  addr;
  } sdcl_cmdbus_t;

  // data pins, three-signal form
  typedef struct packed {
    logic [DATA_W-1:0] dataOut;
    logic [LANES-1:0]  dataOe;
  } sdcl_dq_t;
endpackage

// File: sdcl_mem.sv
// sdcl_mem: byte-lane storage array with registered read data
// assumes: single port, one access per cycle
`timescale 1ns/1ps
module sdcl_mem import sdcl_pkg::*; #(
  parameter int AW = MEM_AW
) (
  input  wire logic              clk,       // clock
  input  wire logic              wrEn,      // write strobe
  input  wire logic [LANES-1:0]  laneEn,    // per-lane write enable
  input  wire logic [AW-1:0]     addr,      // word address
  input  wire logic [DATA_W-1:0] wrData,    // write word
  output logic      [DATA_W-1:0] rdData     // registered read word
);
  logic [DATA_W-1:0] store [0:(1<<AW)-1];

  // lane-gated write, registered read
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : gLane
      always_ff @(posedge clk) begin
        if (wrEn && laneEn[g]) begin
          store[addr][g*8 +: 8] <= wrData[g*8 +: 8];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    rdData <= store[addr];
  end
endmodule

// File: sdcl_device.sv
// sdcl_device: device-side command decoder and data path of a four-bank sdram
// assumes: controller keeps all command spacings; inputs synchronous to clk
// Functional notes
// - clock-enable low sampled: suspend takes effect one cycle later
// - clock-enable high again: resume one cycle later
// - write mask acts on data of the same cycle
// - masked byte lane is not written, zero latency
// - read mask floats that lane two cycles after mask
// - first write word is taken with the write command
// - precharge during read floats outputs after read_latency cycles
// - chip select high makes any command a no-operation
// - outputs are high impedance during initialization once command issued
`timescale 1ns/1ps
module sdcl_device import sdcl_pkg::*; (
  input  wire logic              clk,        // 25 MHz clock
  input  wire logic              reset,      // async, active high
  input  wire logic              clkEnable,  // clock enable pin
  input  wire sdcl_cmdbus_t      cmdBus,     // command and address pins
  input  wire logic [LANES-1:0]  dataMask,   // per-lane mask pins
  input  wire logic [DATA_W-1:0] dataIn,     // data pins, input side
  output sdcl_dq_t               dq,         // data pins, output and enables
  output logic                   suspended,  // device in suspend/power-down
  output logic [1:0]             readLatency // programmed read latency
);
  localparam int PIPE = 4;

  typedef struct packed {
    logic [DATA_W-1:0]              dataHold;  // read word held one cycle for latency 3
    logic                           susp;
    logic [1:0]                     rdLat;
    logic [2:0]                     burstLen;
    logic [3:0]                     bankOpen;
    logic [3:0][ROW_W-1:0]          rowOf;
    logic                           rdAct;
    logic                           wrAct;
    logic [BANK_W-1:0]              curBank;
    logic [COL_W-1:0]               col;
    logic [8:0]                     left;
    logic [PIPE-1:0]                validPipe;
    logic [PIPE-1:0][LANES-1:0]     maskPipe;
    logic [2:0]                     hizCnt;
    sdcl_dq_t                       dqOut;
  } sdcl_state_t;

  sdcl_state_t st_reg, st_next;
  logic [DATA_W-1:0] memRd;
  logic              memWr;
  logic [LANES-1:0]  memLanes;
  logic [MEM_AW-1:0] memAddr;
  logic [DATA_W-1:0] memWd;
  sdcl_cmd_t         cmd;
  logic              active;
  logic [8:0]        burstWords;
  logic [COL_W-1:0]  colStart;
  logic [MEM_AW-1:0] cmdAddr;
  logic [MEM_AW-1:0] streamAddr;

  // command decode; chip select high forces a nop
  always_comb begin
    if (cmdBus.chipSelN) begin
      cmd = CMD_NOP;
    end else begin
      cmd = sdcl_cmd_t'({cmdBus.rowStrobeN, cmdBus.colStrobeN, cmdBus.writeEnN});
    end
  end

  // device acts only while not suspended
  assign active     = !st_reg.susp;
  assign colStart   = cmdBus.addr[COL_W-1:0];
  assign cmdAddr    = {cmdBus.bank, st_reg.rowOf[cmdBus.bank], colStart};
  assign streamAddr = {st_reg.curBank, st_reg.rowOf[st_reg.curBank], st_reg.col};

  // burst length field: 0..3 give 1,2,4,8; 7 gives full page
  always_comb begin
    unique case (st_reg.burstLen)
      3'h0:    burstWords = 9'h001;
      3'h1:    burstWords = 9'h002;
      3'h2:    burstWords = 9'h004;
      3'h3:    burstWords = 9'h008;
      default: burstWords = 9'h100;
    endcase
  end

  // next-state logic
  always_comb begin
    st_next = st_reg;
    memWr    = 1'b0;
    memLanes = '0;
    memWd    = dataIn;
    memAddr  = streamAddr;
    // mask pins are sampled on every edge; under suspend the pipe keeps shifting, so a mask is lost unless resume follows at the next edge
    st_next.maskPipe = {st_reg.maskPipe[PIPE-2:0], dataMask};
    // clock enable sampled low here stops the device from the next edge on
    st_next.susp = !clkEnable;
    // read pipeline advances only when not suspended
    if (active) begin
      st_next.validPipe = {st_reg.validPipe[PIPE-2:0], 1'b0};
      st_next.dataHold  = memRd; // word read one edge ago, used at latency 3
      if (st_reg.hizCnt != 3'h0) begin
        st_next.hizCnt = st_reg.hizCnt - 3'h1;
      end
      // continue an ongoing burst
      if (st_reg.left != 9'h000) begin
        if (st_reg.wrAct) begin
          memWr    = 1'b1;
          memLanes = ~dataMask;
        end
        st_next.col  = st_reg.col + COL_W'(1);
        st_next.left = st_reg.left - 9'h001;
        if (st_reg.rdAct) begin
          st_next.validPipe[0] = 1'b1;
        end
        if (st_reg.left == 9'h001) begin
          st_next.rdAct = 1'b0;
          st_next.wrAct = 1'b0;
        end
      end
      unique case (cmd)
        CMD_MODE: begin
          st_next.rdLat    = cmdBus.addr[5:4];
          st_next.burstLen = cmdBus.addr[2:0];
        end
        CMD_ACT: begin
          st_next.bankOpen[cmdBus.bank] = 1'b1;
          st_next.rowOf[cmdBus.bank]    = cmdBus.addr;
        end
        CMD_PRE: begin
          if (cmdBus.addr[10]) begin
            st_next.bankOpen = '0;
          end else begin
            st_next.bankOpen[cmdBus.bank] = 1'b0;
          end
          if (st_reg.rdAct && (cmdBus.addr[10] || cmdBus.bank == st_reg.curBank)) begin
            st_next.rdAct = 1'b0;
            st_next.left  = 9'h000;
            // float after read_latency cycles
            st_next.hizCnt = (st_reg.rdLat == 2'h2) ?
                             3'(PRECHARGE_TO_OUTPUT_HIZ_CL2) :
                             3'(PRECHARGE_TO_OUTPUT_HIZ_CL3);
          end
        end
        CMD_STOP: begin
          st_next.rdAct = 1'b0;
          st_next.wrAct = 1'b0;
          st_next.left  = 9'h000;
        end
        CMD_READ: begin
          st_next.rdAct   = 1'b1;
          st_next.wrAct   = 1'b0;
          st_next.curBank = cmdBus.bank;
          memAddr         = cmdAddr;
          st_next.validPipe[0] = 1'b1;
          st_next.col     = colStart + COL_W'(1);
          st_next.left    = burstWords - 9'h001;
          st_next.hizCnt  = 3'h0;
        end
        CMD_WRITE: begin
          // first word taken together with the command
          memWr    = 1'b1;
          memLanes = ~dataMask;
          memAddr  = cmdAddr;
          st_next.wrAct   = 1'b1;
          st_next.rdAct   = 1'b0;
          st_next.curBank = cmdBus.bank;
          st_next.col     = colStart + COL_W'(1);
          st_next.left    = burstWords - 9'h001;
          st_next.validPipe = '0;
        end
        default: begin
        end
      endcase
    end
    // read data leaves at latency; mask delayed two cycles floats lanes
    // latency 2 takes the array word directly, latency 3 the held copy
    st_next.dqOut.dataOut = (st_reg.rdLat == 2'h2) ? memRd : st_reg.dataHold;
    st_next.dqOut.dataOe  = '0;
    if (active) begin
      if (st_reg.validPipe[st_reg.rdLat - 2'h2] && st_next.hizCnt != 3'h1 &&
          st_reg.hizCnt != 3'h1) begin
        st_next.dqOut.dataOe = ~st_reg.maskPipe[READ_MASK_HIZ_LATENCY - 2];
      end
    end else begin
      st_next.dqOut = st_reg.dqOut; // outputs frozen in suspend
    end
  end

  // storage array
  sdcl_mem #(.AW(MEM_AW)) uMem (
    .clk    (clk),
    .wrEn   (memWr),
    .laneEn (memLanes),
    .addr   (memAddr),
    .wrData (memWd),
    .rdData (memRd)
  );

  // state register; outputs float from reset through initialization
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg          <= '0;
      st_reg.susp     <= 1'b0; // running after reset
      st_reg.rdLat    <= READ_LATENCY_RESET;
      st_reg.burstLen <= BURST_LEN_RESET;
      st_reg.dqOut    <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dq          = st_reg.dqOut;
  assign suspended   = st_reg.susp;
  assign readLatency = st_reg.rdLat;
endmodule

// File: sdcl_device_sva.sv
// sdcl_device_sva: pin timing checks for the device core
// assumes: bound to sdcl_device, single clock domain
`timescale 1ns/1ps
module sdcl_device_chk import sdcl_pkg::*; (
  input wire logic             clk,         // clock
  input wire logic             reset,       // async reset
  input wire logic             clkEnable,   // clock enable
  input wire sdcl_cmdbus_t     cmdBus,      // command pins
  input wire logic [LANES-1:0] dataMask,    // mask pins
  input wire sdcl_dq_t         dq,          // data out and enables
  input wire logic             suspended,   // suspend flag
  input wire logic [1:0]       readLatency  // programmed latency
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // precharge accepted at this edge
  // precharge of all banks accepted at this edge (device not suspended)
  wire pre = !cmdBus.chipSelN && !suspended && cmdBus.addr[10] &&
             {cmdBus.rowStrobeN, cmdBus.colStrobeN, cmdBus.writeEnN} == CMD_PRE;
  susp_entry_a: assert property (!clkEnable |=> suspended)
    else $error("suspend entry late");
  susp_exit_a: assert property (clkEnable && suspended |=> !suspended)
    else $error("suspend exit late");
  mask_lane0_a: assert property ((dataMask[0] && clkEnable) ##1 clkEnable |=> !dq.dataOe[0])
    else $error("lane 0 driven under read mask");
  mask_lane3_a: assert property (dataMask[3] && clkEnable ##1 clkEnable |-> ##1 !dq.dataOe[3])
    else $error("lane 3 driven under read mask");
  pre_float3_a: assert property (pre && clkEnable && readLatency == 2'h3 ##1 clkEnable |-> ##2 dq.dataOe == 4'h0)
    else $error("outputs not floated after precharge at latency 3");
  pre_float2_a: assert property (pre && clkEnable && readLatency == 2'h2 |-> ##2 dq.dataOe == 4'h0)
    else $error("outputs not floated after precharge at latency 2");
  desel_nop_a: assert property (cmdBus.chipSelN |=> $stable(readLatency))
    else $error("deselected command changed mode");
  init_hiz_a: assert property ($past(reset) |-> dq.dataOe == 4'h0)
    else $error("outputs driven after reset");
endmodule
bind sdcl_device sdcl_device_chk i_chk (.clk(clk), .reset(reset), .clkEnable(clkEnable),
  .cmdBus(cmdBus), .dataMask(dataMask), .dq(dq), .suspended(suspended), .readLatency(readLatency));

// File: sdcl_ctrl_model.sv
// sdcl_ctrl_model: controller side, turns bench requests into command pins
// assumes: requests change just after the rising edge
`timescale 1ns/1ps
module sdcl_ctrl_model import sdcl_pkg::*; (
  input  wire logic              issue,    // command wanted this cycle
  input  wire logic              deselect, // drive command with chip select high
  input  wire sdcl_cmd_t         cmd,      // command code
  input  wire logic [BANK_W-1:0] bank,     // bank select
  input  wire logic [ROW_W-1:0]  addr,     // address pins
  output sdcl_cmdbus_t           cmdBus    // command pins
);
  // nop whenever nothing is due, one command per cycle at most
  always_comb begin
    cmdBus = {1'b0, CMD_NOP, bank, addr};
    if (issue) begin
      cmdBus = {deselect, cmd, bank, addr};
    end
  end
endmodule

// File: testbench.sv
// testbench: drives the device through the controller model, checks read data
// assumes: 25 MHz clock, burst length 1 after reset
`timescale 1ns/1ps
module testbench import sdcl_pkg::*;;
  logic              clk, reset, clkEnable, issue, deselect, suspended;
  sdcl_cmd_t         cmd;
  logic [BANK_W-1:0] bank;
  logic [ROW_W-1:0]  addr;
  logic [LANES-1:0]  dataMask;
  logic [DATA_W-1:0] dataIn, a, b, e, lm;
  logic [15:0]       seed;
  logic [1:0]        readLatency;
  logic [35:0]       q;
  sdcl_cmdbus_t      cmdBus;
  sdcl_dq_t          dq;
  logic [35:0]       expQ[$];
  int                mismatches, compares;

  sdcl_ctrl_model i_ctrl (.issue(issue), .deselect(deselect), .cmd(cmd), .bank(bank),
    .addr(addr), .cmdBus(cmdBus));
  sdcl_device i_dut (.clk(clk), .reset(reset), .clkEnable(clkEnable), .cmdBus(cmdBus),
    .dataMask(dataMask), .dataIn(dataIn), .dq(dq), .suspended(suspended),
    .readLatency(readLatency));

  // clock
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic test_done;
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step(input sdcl_cmd_t c, input logic [ROW_W-1:0] ad,
                      input logic [DATA_W-1:0] d, input logic [LANES-1:0] m, input logic ds);
    issue = 1; cmd = c; addr = ad; dataIn = d; dataMask = m; deselect = ds;
    @(posedge clk); #1;
  endtask

  task automatic idle(input int n);
    issue = 0; dataMask = 0; deselect = 0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  // main sequence
  initial begin
    reset = 1; clkEnable = 1; issue = 0; deselect = 0; cmd = CMD_NOP; bank = 0;
    addr = 0; dataMask = 0; dataIn = 0; mismatches = 0; compares = 0; seed = 16'ha378;
    repeat (2) @(posedge clk);
    #1 reset = 0;
    check({25'h0, dq.dataOe, suspended, readLatency}, 32'h3);
    step(CMD_MODE, 11'h030, 0, 0, 0); idle(2);
    step(CMD_REFR, 0, 0, 0, 0); step(CMD_REFR, 0, 0, 0, 0); idle(2);
    seed = lfsr(seed); a = {seed, ~seed};
    seed = lfsr(seed); b = {~seed, seed};
    e = {a[31:24], b[23:0]};
    step(CMD_ACT, 0, 0, 0, 0); idle(2);
    step(CMD_WRITE, 5, a, 0, 0);
    step(CMD_WRITE, 5, b, 4'h8, 0);
    step(CMD_STOP, 0, 0, 0, 0); expQ.push_back({e, 4'hf});
    step(CMD_READ, 5, 0, 0, 0); idle(4);
    step(CMD_PRE, 11'h400, 0, 0, 0); idle(3);
    step(CMD_MODE, 11'h020, 0, 0, 0); idle(2);
    check({30'h0, readLatency}, 32'h2);
    step(CMD_ACT, 0, 0, 0, 0); idle(2);
    expQ.push_back({e, 4'he}); expQ.push_back({e, 4'hf});
    step(CMD_READ, 5, 0, 4'h1, 0);
    step(CMD_READ, 5, 0, 0, 0); idle(4);
    step(CMD_WRITE, 5, ~e, 0, 1); idle(1);
    expQ.push_back({e, 4'hf});
    step(CMD_READ, 5, 0, 0, 0); idle(4);
    step(CMD_PRE, 11'h400, 0, 0, 0); idle(3);
    // latency 3, burst 4: a precharge right after the read leaves one word
    step(CMD_MODE, 11'h032, 0, 0, 0); idle(2);
    step(CMD_ACT, 0, 0, 0, 0); idle(2);
    expQ.push_back({e, 4'hf});
    step(CMD_READ, 5, 0, 0, 0);
    step(CMD_PRE, 11'h400, 0, 0, 0); idle(5);
    clkEnable = 0; idle(3);
    check({31'h0, suspended}, 32'h1);
    clkEnable = 1; idle(2);
    check({31'h0, suspended}, 32'h0);
    idle(4);
    check(32'(expQ.size()), 32'h0);
    test_done;
  end

  // watches driven read words and compares them with the oldest note
  always @(posedge clk) begin
    #2;
    if (!reset && dq.dataOe !== 4'h0) begin
      q = (expQ.size() > 0) ? expQ.pop_front() : 36'h0;
      lm = {{8{q[3]}}, {8{q[2]}}, {8{q[1]}}, {8{q[0]}}};
      check({28'h0, dq.dataOe}, {28'h0, q[3:0]});
      check(dq.dataOut & lm, q[35:4] & lm);
    end
  end

  // watchdog
  initial begin
    #20000;
    mismatches++;
    test_done;
  end
endmodule
